// File: rtl/adc_ctrl_pkg.sv
// constants, register map and carrier types for the converter control block
// assumes a single 100 MHz clock and an AHB-Lite register bus
package adc_ctrl_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL_ONE = 8'h00;
    localparam logic [7:0] OFF_CTRL_TWO = 8'h04;
    localparam logic [7:0] OFF_RES_HIGH = 8'h08;
    localparam logic [7:0] OFF_RES_LOW = 8'h0C;
    localparam logic [7:0] OFF_CFG = 8'h10;
    localparam logic [7:0] OFF_CMP_VAL = 8'h14;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h1C;
    // field positions
    localparam int CTWO_ACTIVE = 7;
    localparam int CTWO_TRIG_SEL = 6;
    localparam int CTWO_CMP_EN = 5;
    localparam int CTWO_CMP_GE = 4;
    localparam int CFG_LONG_SAMPLE = 4;
    // channel numbers of internal sources
    localparam logic [4:0] TEMP_SENSOR_CHANNEL = 5'h1A;
    localparam logic [4:0] BANDGAP_CHANNEL = 5'h1B;
    // sample windows in half cycles of the converter clock
    localparam int SHORT_SAMPLE_HALF = 7;
    localparam int LONG_SAMPLE_HALF = 47;
    localparam logic [5:0] SHORT_SAMPLE_CYC = 6'((SHORT_SAMPLE_HALF + 1) / 2);
    localparam logic [5:0] LONG_SAMPLE_CYC = 6'((LONG_SAMPLE_HALF + 1) / 2);
    localparam logic [3:0] CONVERT_CYC = 4'hC;
    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [11:0] RESULT_RESET = 12'h000;
    // resolution codes
    typedef enum logic [1:0] {RES_8 = 2'b00, RES_12 = 2'b01,
        RES_10 = 2'b10} res_mode_t;
    // analog side request and answer
    typedef struct packed {
        logic start;
        logic [4:0] channel;
    } conv_req_t;
    typedef struct packed {
        logic done;
        logic [11:0] value;
    } conv_ans_t;
    // interrupt events
    typedef struct packed {
        logic dropped;
        logic complete;
    } irq_ev_t;
endpackage

// File: rtl/adc_result_format.sv
// trims a raw result to the resolution and applies compare arithmetic
// assumes raw data is left in the low bits as the converter delivers it
`timescale 1ns/1ns
`default_nettype none
module adc_result_format (
    // conversion input
    input wire logic [11:0] raw,
    input wire adc_ctrl_pkg::res_mode_t res,
    // compare settings
    input wire logic cmp_en,
    input wire logic cmp_ge,
    input wire logic [11:0] cmp_val,
    // outputs
    output logic [11:0] value,
    output logic store_ok
);
    import adc_ctrl_pkg::*;
    logic [11:0] trimmed;
    logic [11:0] cmp_trim;
    logic lower;
    // clear upper bits by resolution
    always_comb begin
        case (res)
            RES_12: begin
                trimmed = raw;
                cmp_trim = cmp_val;
            end
            RES_10: begin
                trimmed = {2'b00, raw[9:0]};
                cmp_trim = {2'b00, cmp_val[9:0]};
            end
            default: begin
                trimmed = {4'h0, raw[7:0]};
                cmp_trim = {4'h0, cmp_val[7:0]};
            end
        endcase
    end
    // compare sense and stored difference
    always_comb begin
        lower = trimmed < cmp_trim;
        store_ok = !cmp_en || (cmp_ge ? !lower : lower);
        if (cmp_en) begin
            value = 12'(trimmed + ~cmp_trim + 12'h001);
        end else begin
            value = trimmed;
        end
    end
endmodule
`default_nettype wire

// File: rtl/adc_trigger_compare_result.sv
// assumes a lone AHB-Lite master and a converter clock equal to MCLK
`timescale 1ns/1ns
`default_nettype none
module adc_trigger_compare_result (
    // clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // ahb-lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // trigger and analog side
    input wire logic HARDWARE_TRIGGER_INPUT,
    input wire adc_ctrl_pkg::conv_ans_t CONV_ANS,
    output adc_ctrl_pkg::conv_req_t CONV_REQ,
    output logic SAMPLING,
    // interrupt
    output logic IRQ
);
    import adc_ctrl_pkg::*;
    typedef enum {ST_IDLE, ST_SAMPLE, ST_CONVERT} state_t;
    state_t state_reg;
    logic [7:0] ctrl_one_reg;
    logic trig_sel_reg, cmp_en_reg, cmp_ge_reg;
    logic [7:0] cfg_reg;
    logic [11:0] cmp_val_reg;
    logic [11:0] result_reg;
    logic locked_reg;
    irq_ev_t irq_stat_reg, irq_mask_reg;
    logic [5:0] count_reg;
    logic wr_pend_reg, rd_pend_reg;
    logic [7:0] addr_reg;
    logic trig_prev_reg;
    logic [31:0] rdata_next;
    logic active, start_sw, start_hw, start, abort;
    logic wr_one, wr_two, rd_high, rd_low, done, load, blocked, store_ok;
    logic [11:0] value;
    res_mode_t res;
    logic [5:0] sample_len;

    // address phase capture
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= HSEL && HREADY && HTRANS[1] && HWRITE;
            rd_pend_reg <= HSEL && HREADY && HTRANS[1] && !HWRITE;
            if (HSEL && HREADY && HTRANS[1]) begin
                addr_reg <= HADDR[7:0];
            end
        end
    end

    // decoded accesses and configuration views
    assign wr_one = wr_pend_reg && addr_reg == OFF_CTRL_ONE;
    assign wr_two = wr_pend_reg && addr_reg == OFF_CTRL_TWO;
    assign rd_high = rd_pend_reg && addr_reg == OFF_RES_HIGH;
    assign rd_low = rd_pend_reg && addr_reg == OFF_RES_LOW;
    assign res = res_mode_t'(cfg_reg[3:2]);
    assign active = state_reg != ST_IDLE;
    assign start_sw = wr_one && !trig_sel_reg;
    assign start_hw = trig_sel_reg && HARDWARE_TRIGGER_INPUT
        && !trig_prev_reg;
    assign start = (start_sw || start_hw) && !active;
    assign abort = wr_one && active; // a new channel write aborts
    assign done = state_reg == ST_CONVERT && CONV_ANS.done;
    assign blocked = locked_reg && res != RES_8;
    assign load = done && store_ok && !blocked;
    assign sample_len = cfg_reg[CFG_LONG_SAMPLE] ?
        LONG_SAMPLE_CYC : SHORT_SAMPLE_CYC;

    adc_result_format adc_result_format_i (
        .raw(CONV_ANS.value),
        .res(res),
        .cmp_en(cmp_en_reg),
        .cmp_ge(cmp_ge_reg),
        .cmp_val(cmp_val_reg),
        .value(value),
        .store_ok(store_ok)
    );

    // register writes
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            ctrl_one_reg <= CTRL_RESET;
            trig_sel_reg <= 1'b0;
            cmp_en_reg <= 1'b0;
            cmp_ge_reg <= 1'b0;
            cfg_reg <= CTRL_RESET;
            cmp_val_reg <= RESULT_RESET;
            irq_mask_reg <= '0;
        end else if (wr_pend_reg) begin
            if (wr_one) begin
                ctrl_one_reg <= HWDATA[7:0];
            end
            if (wr_two) begin
                trig_sel_reg <= HWDATA[CTWO_TRIG_SEL];
                cmp_en_reg <= HWDATA[CTWO_CMP_EN];
                cmp_ge_reg <= HWDATA[CTWO_CMP_GE];
            end
            if (addr_reg == OFF_CFG) begin
                cfg_reg <= HWDATA[7:0];
            end
            if (addr_reg == OFF_CMP_VAL) begin
                cmp_val_reg <= HWDATA[11:0];
            end
            if (addr_reg == OFF_IRQ_MASK) begin
                irq_mask_reg <= HWDATA[1:0];
            end
        end
    end

    // conversion sequencer
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            state_reg <= ST_IDLE;
            count_reg <= 6'h00;
            trig_prev_reg <= 1'b0;
        end else begin
            trig_prev_reg <= HARDWARE_TRIGGER_INPUT;
            case (state_reg)
                ST_IDLE: begin
                    if (start) begin
                        state_reg <= ST_SAMPLE;
                        count_reg <= sample_len;
                    end
                end
                ST_SAMPLE: begin
                    if (abort) begin
                        state_reg <= ST_IDLE;
                    end else if (count_reg == 6'h01) begin
                        state_reg <= ST_CONVERT;
                    end else begin
                        count_reg <= 6'(count_reg - 6'h01);
                    end
                end
                ST_CONVERT: begin
                    if (abort || CONV_ANS.done) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // analog request, channel steering and sample window
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            CONV_REQ <= '0;
            SAMPLING <= 1'b0;
        end else begin
            CONV_REQ.start <= state_reg == ST_SAMPLE && count_reg == 6'h01
                && !abort;
            CONV_REQ.channel <= ctrl_one_reg[4:0];
            SAMPLING <= state_reg == ST_SAMPLE && !abort;
        end
    end

    // result store and read interlock
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            result_reg <= RESULT_RESET;
            locked_reg <= 1'b0;
        end else begin
            if (load) begin
                result_reg <= value;
            end
            if (rd_high) begin
                locked_reg <= 1'b1;
            end else if (rd_low) begin
                locked_reg <= 1'b0;
            end
        end
    end

    // sticky interrupt status, set wins over write-one clear
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            irq_stat_reg <= '0;
        end else begin
            irq_stat_reg.complete <= load || (irq_stat_reg.complete &&
                !(wr_pend_reg && addr_reg == OFF_IRQ_STAT && HWDATA[0]));
            irq_stat_reg.dropped <= (done && blocked) ||
                (irq_stat_reg.dropped &&
                !(wr_pend_reg && addr_reg == OFF_IRQ_STAT && HWDATA[1]));
        end
    end

    // read data multiplexer
    always_comb begin
        case (addr_reg)
            OFF_CTRL_ONE: rdata_next = {24'h00_0000, ctrl_one_reg};
            OFF_CTRL_TWO: rdata_next = {24'h00_0000, active, trig_sel_reg,
                cmp_en_reg, cmp_ge_reg, 4'h0};
            OFF_RES_HIGH: rdata_next = {28'h000_0000, result_reg[11:8]};
            OFF_RES_LOW: rdata_next = {24'h00_0000, result_reg[7:0]};
            OFF_CFG: rdata_next = {24'h00_0000, cfg_reg};
            OFF_CMP_VAL: rdata_next = {20'h0_0000, cmp_val_reg};
            OFF_IRQ_STAT: rdata_next = {30'h0000_0000, irq_stat_reg};
            OFF_IRQ_MASK: rdata_next = {30'h0000_0000, irq_mask_reg};
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    // bus answers and interrupt line
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            HRDATA <= 32'h0000_0000;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
            IRQ <= 1'b0;
        end else begin
            HRDATA <= rdata_next;
            HREADYOUT <= !(HSEL && HREADY && HTRANS[1] && !HWRITE);
            HRESP <= 1'b0;
            IRQ <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // checks on start, sample window, store and interlock
    a_active_tracks: assert property (
        @(posedge MCLK) disable iff (RST)
        start |=> active)
        else $error("active not set on start");
    a_active_clear: assert property (
        @(posedge MCLK) disable iff (RST)
        active && done |=> !active)
        else $error("active not cleared on completion");
    a_abort_stop: assert property (
        @(posedge MCLK) disable iff (RST)
        abort |=> state_reg == ST_IDLE)
        else $error("abort did not stop the conversion");
    a_sw_start: assert property (
        @(posedge MCLK) disable iff (RST)
        wr_one && !trig_sel_reg && !active |=> state_reg == ST_SAMPLE)
        else $error("software start missed");
    a_sw_ignore: assert property (
        @(posedge MCLK) disable iff (RST)
        wr_one && trig_sel_reg && !active && !start_hw
        |=> state_reg == ST_IDLE)
        else $error("software write started a hardware mode conversion");
    // sampling output rises one cycle after the state leaves idle
    a_hw_start: assert property (
        @(posedge MCLK) disable iff (RST)
        start_hw && !active |=> state_reg == ST_SAMPLE ##1 SAMPLING)
        else $error("hardware start missed");
    a_cmp_hold: assert property (
        @(posedge MCLK) disable iff (RST)
        done && cmp_en_reg && !store_ok |=> $stable(result_reg))
        else $error("result changed on failed compare");
    a_load_value: assert property (
        @(posedge MCLK) disable iff (RST)
        load |=> result_reg == $past(value))
        else $error("loaded result differs from formatted value");
    a_block_keep: assert property (
        @(posedge MCLK) disable iff (RST)
        done && blocked |=> $stable(result_reg))
        else $error("blocked result was stored");
    a_drop_flag: assert property (
        @(posedge MCLK) disable iff (RST)
        done && blocked |=> irq_stat_reg.dropped)
        else $error("discarded result not flagged");
    a_lock_set: assert property (
        @(posedge MCLK) disable iff (RST)
        rd_high ##1 !rd_low |-> locked_reg)
        else $error("high read did not lock");
    a_lock_free: assert property (
        @(posedge MCLK) disable iff (RST)
        rd_low && !rd_high |=> !locked_reg)
        else $error("low read did not unlock");
    a_eight_load: assert property (
        @(posedge MCLK) disable iff (RST)
        done && store_ok && locked_reg && res == RES_8
        |=> result_reg == $past(value))
        else $error("eight bit result held by interlock");
    a_trim_ten: assert property (
        @(posedge MCLK) disable iff (RST)
        load && res == RES_10 && !cmp_en_reg
        |=> result_reg[11:10] == 2'b00)
        else $error("upper bits not cleared");
    a_trim_eight: assert property (
        @(posedge MCLK) disable iff (RST)
        load && res == RES_8 && !cmp_en_reg
        |=> result_reg[11:8] == 4'h0)
        else $error("upper nibble not cleared");
    a_sample_len: assert property (
        @(posedge MCLK) disable iff (RST)
        start && !cfg_reg[CFG_LONG_SAMPLE]
        |=> ##1 SAMPLING [*4] ##1 !SAMPLING)
        else $error("short sample length wrong");
    a_long_load: assert property (
        @(posedge MCLK) disable iff (RST)
        start && cfg_reg[CFG_LONG_SAMPLE] |=> count_reg == LONG_SAMPLE_CYC)
        else $error("long sample count wrong");
    c_conv_done: cover property (@(posedge MCLK) load);
    c_drop: cover property (@(posedge MCLK) done && blocked);
    c_cmp_event: cover property (@(posedge MCLK) load && cmp_en_reg);
    c_irq: cover property (@(posedge MCLK) IRQ);
    c_abort: cover property (@(posedge MCLK) abort);
endmodule
`default_nettype wire

// File: sim/adc_analog_model.sv
// analog side model: answers each start pulse after a set latency
// assumes the block sends a one-cycle start pulse with the channel
`timescale 1ns/1ns
`default_nettype none
module adc_analog_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // request from the block and answer to it
    input wire adc_ctrl_pkg::conv_req_t req,
    output adc_ctrl_pkg::conv_ans_t ans,
    // bench controls and observation
    input wire logic [11:0] sample_val,
    input wire logic [7:0] lat,
    output logic [4:0] got_ch
);
    import adc_ctrl_pkg::*;
    logic [7:0] wait_reg;
    logic busy_reg;
    // count out the latency, pulse done; value toggles when not valid
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_reg <= 1'b0;
            wait_reg <= 8'h00;
            got_ch <= 5'h00;
            ans <= '0;
        end else begin
            ans.done <= 1'b0;
            ans.value <= ~ans.value;
            if (req.start) begin
                busy_reg <= 1'b1;
                wait_reg <= lat;
                got_ch <= req.channel;
            end else if (busy_reg && wait_reg == 8'h00) begin
                busy_reg <= 1'b0;
                ans.done <= 1'b1;
                ans.value <= sample_val;
            end else if (busy_reg) begin
                wait_reg <= wait_reg - 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// File: sim/adc_trigger_compare_result_tb_top.sv
// bench for the converter control block: register calls with expectations
// assumes one AHB-Lite master here and the analog model on the far side
`timescale 1ns/1ns
`default_nettype none
module adc_trigger_compare_result_tb_top;
    import adc_ctrl_pkg::*;
    logic MCLK = 1'b0;
    logic RST = 1'b0;
    logic HSEL = 1'b0;
    logic [31:0] HADDR = 32'h0000_0000;
    logic [1:0] HTRANS = 2'b00;
    logic HWRITE = 1'b0;
    logic [2:0] HSIZE = 3'h2;
    logic [31:0] HWDATA = 32'h0000_0000;
    logic hw_trig = 1'b0;
    logic [11:0] sample_val = 12'h000;
    logic [7:0] lat = 8'h01;
    wire logic [31:0] HRDATA;
    wire logic HREADYOUT;
    wire logic HRESP;
    wire logic SAMPLING;
    wire logic IRQ;
    wire logic [4:0] got_ch;
    conv_ans_t conv_ans;
    conv_req_t conv_req;
    logic [31:0] rd;
    int err_count = 0;
    int n_compared = 0;
    int samp_run = 0;
    int samp_len = 0;
    int samp_starts = 0;
    int n;
    logic [7:0] c_ctl [5] = '{8'h20, 8'h20, 8'h30, 8'h30, 8'h00};
    logic [11:0] c_raw [5] = '{12'h200, 12'h080, 12'h300, 12'h0F0, 12'h050};
    logic [11:0] c_exp [5] = '{12'h055, 12'hF80, 12'h200, 12'h200, 12'h050};

    // clock
    always #5 MCLK = ~MCLK;

    adc_trigger_compare_result adc_trigger_compare_result_i (
        .MCLK(MCLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
        .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP),
        .HARDWARE_TRIGGER_INPUT(hw_trig), .CONV_ANS(conv_ans),
        .CONV_REQ(conv_req), .SAMPLING(SAMPLING), .IRQ(IRQ));

    adc_analog_model adc_analog_model_i (
        .clk(MCLK), .rst(RST), .req(conv_req), .ans(conv_ans),
        .sample_val(sample_val), .lat(lat), .got_ch(got_ch));

    // measures sample window length and counts windows
    always @(posedge MCLK) begin
        if (SAMPLING === 1'b1) begin
            if (samp_run == 0) samp_starts <= samp_starts + 1;
            samp_run <= samp_run + 1;
        end else begin
            if (samp_run != 0) samp_len <= samp_run;
            samp_run <= 0;
        end
    end

    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one single-word transfer: address phase, then data phase
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] q);
        @(posedge MCLK);
        HSEL <= 1'b1;
        HTRANS <= 2'b10;
        HADDR <= {24'h00_0000, a};
        HWRITE <= w;
        do @(posedge MCLK); while (HREADYOUT !== 1'b1);
        HTRANS <= 2'b00;
        HWDATA <= d;
        do @(posedge MCLK); while (HREADYOUT !== 1'b1);
        q = HRDATA;
    endtask

    task rd_chk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000, rd);
        chk(rd, e);
    endtask

    task res_chk(input logic [11:0] e);
        rd_chk(OFF_RES_HIGH, {28'h000_0000, e[11:8]});
        rd_chk(OFF_RES_LOW, {24'h00_0000, e[7:0]});
    endtask

    task cfg(input logic lng, input res_mode_t r);
        bus(1'b1, OFF_CFG, {27'h000_0000, lng, r, 2'b00}, rd);
    endtask

    task wait_done;
        @(posedge MCLK iff conv_ans.done === 1'b1);
        repeat (3) @(posedge MCLK);
    endtask

    task conv(input logic [4:0] ch, input logic [11:0] v);
        sample_val <= v;
        bus(1'b1, OFF_CTRL_ONE, {27'h000_0000, ch}, rd);
        wait_done;
        chk({27'h000_0000, got_ch}, {27'h000_0000, ch});
    endtask

    // watchdog
    initial begin
        #100_000;
        err_count++;
        $display("ERROR at %0t: watchdog expired", $time);
        end_sim;
    end

    // main sequence
    initial begin
        RST = 1'b1;
        repeat (10) @(posedge MCLK);
        RST <= 1'b0;
        rd_chk(OFF_CTRL_TWO, {24'h00_0000, CTRL_RESET});
        res_chk(12'h000);
        rd_chk(8'h40, 32'h0000_0000);
        $display("test reset done");
        cfg(1'b0, RES_12);
        lat <= 8'h28;
        sample_val <= 12'hABC;
        bus(1'b1, OFF_CTRL_ONE, 32'h0000_0005, rd);
        rd_chk(OFF_CTRL_TWO, 32'h0000_0080);
        wait_done;
        rd_chk(OFF_CTRL_TWO, 32'h0000_0000);
        chk(32'(samp_len), 32'h0000_0004);
        res_chk(12'hABC);
        bus(1'b1, OFF_CTRL_ONE, 32'h0000_0005, rd);
        bus(1'b1, OFF_CTRL_ONE, 32'h0000_0005, rd);
        rd_chk(OFF_CTRL_TWO, 32'h0000_0000);
        lat <= 8'h01;
        $display("test software trigger done");
        cfg(1'b0, RES_10);
        conv(5'h03, 12'hFFF);
        res_chk(12'h3FF);
        cfg(1'b0, RES_8);
        conv(5'h03, 12'hFFF);
        res_chk(12'h0FF);
        $display("test resolution done");
        cfg(1'b0, RES_12);
        bus(1'b1, OFF_IRQ_STAT, 32'h0000_0003, rd);
        conv(5'h01, 12'h123);
        rd_chk(OFF_RES_HIGH, 32'h0000_0001);
        conv(5'h01, 12'h456);
        rd_chk(OFF_RES_LOW, 32'h0000_0023);
        bus(1'b0, OFF_IRQ_STAT, 32'h0000_0000, rd);
        chk(rd & 32'h0000_0002, 32'h0000_0002);
        conv(5'h01, 12'h789);
        res_chk(12'h789);
        cfg(1'b0, RES_8);
        conv(5'h01, 12'h0AA);
        rd_chk(OFF_RES_HIGH, 32'h0000_0000);
        conv(5'h01, 12'h055);
        rd_chk(OFF_RES_LOW, 32'h0000_0055);
        $display("test interlock done");
        cfg(1'b0, RES_12);
        bus(1'b1, OFF_CMP_VAL, 32'h0000_0100, rd);
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, OFF_CTRL_TWO, {24'h00_0000, c_ctl[i]}, rd);
            conv(5'h01, c_raw[i]);
            res_chk(c_exp[i]);
        end
        $display("test compare done");
        bus(1'b1, OFF_CTRL_TWO, 32'h0000_0040, rd);
        cfg(1'b1, RES_12);
        n = samp_starts;
        bus(1'b1, OFF_CTRL_ONE, {27'h000_0000, TEMP_SENSOR_CHANNEL}, rd);
        repeat (10) @(posedge MCLK);
        chk(32'(samp_starts), 32'(n));
        sample_val <= 12'h321;
        hw_trig <= 1'b1;
        wait_done;
        hw_trig <= 1'b0;
        chk({27'h000_0000, got_ch}, {27'h000_0000, TEMP_SENSOR_CHANNEL});
        chk(32'(samp_len), 32'h0000_0018);
        res_chk(12'h321);
        bus(1'b1, OFF_CTRL_TWO, 32'h0000_0000, rd);
        conv(BANDGAP_CHANNEL, 12'h7FF);
        $display("test hardware trigger done");
        bus(1'b1, OFF_IRQ_STAT, 32'h0000_0003, rd);
        bus(1'b1, OFF_IRQ_MASK, 32'h0000_0000, rd);
        conv(5'h02, 12'h111);
        chk({31'h0000_0000, IRQ}, 32'h0000_0000);
        bus(1'b1, OFF_IRQ_MASK, 32'h0000_0001, rd);
        repeat (2) @(posedge MCLK);
        chk({31'h0000_0000, IRQ}, 32'h0000_0001);
        rd_chk(OFF_IRQ_STAT, 32'h0000_0001);
        bus(1'b1, OFF_IRQ_STAT, 32'h0000_0001, rd);
        repeat (2) @(posedge MCLK);
        chk({31'h0000_0000, IRQ}, 32'h0000_0000);
        chk({31'h0000_0000, HRESP}, 32'h0000_0000);
        $display("test interrupt done");
        end_sim;
    end
endmodule
`default_nettype wire
